// *** logic/sfo_top.sv ***
`timescale 1ns/10ps
// Function
// - Pin level sampled during reset; high selects two write enables, offsets not loadable.
// - Two-enable mode: store word each write clock rise, enable one low, two high.
// - Two-enable mode: either enable inactive means nothing stored.
// - Both write enables ignored while full flag is low.
// - Full flag returns high on write clock after a read frees space.
// - Load pin low at reset selects mode with four loadable readable offset registers.
// - Offset writes step cyclically: empty low, empty high, full low, full high.
// - Sequence position kept while load pin high; normal operation resumes.
// - Load low and reads enabled: next offset register driven onto output, same order.
// - Full flag low when stored count equals depth.
// - Full and almost-full flags change only on write clock rises.
// - Empty and almost-empty flags change only on read clock rises.
// - Empty flag low when pointers equal; reads inhibited while empty.
// - Almost-full low at count of depth minus full offset and above.
// - Default full offset gives almost-full at seven or fewer free places.
// - Almost-empty low while count at most empty offset, high above it.
// - Default empty offset gives almost-empty low at seven or fewer words.
// - Read and write data are both nine bits wide.
// - Reset clears pointers, output register, and restores offset defaults.
// - Reset drives full flags high and empty flags low.
// - Offset mode: enable one is the only write enable, load pin high.
module sfo_top
  import sfo_pkg::*;
#(
  parameter int DEPTH = sfo_pkg::FIFO_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic write_clock,
  input wire logic read_clock,
  input wire logic write_enable_one,
  input wire logic write_enable_two_load,
  input wire logic read_enable_one,
  input wire logic read_enable_two,
  input wire logic [sfo_pkg::DATA_W-1:0] write_data_in,
  output logic [sfo_pkg::DATA_W-1:0] read_data_out,
  output logic full_flag_n,
  output logic empty_flag,
  output logic almost_full_flag,
  output logic almost_empty_flag
);
  import sfo_pkg::*;

  localparam int PW = AW + 1;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
  localparam logic [PW-1:0] PTR_ZERO = '0;
  localparam logic [PW-1:0] PTR_ONE = PW'(1);

  // Pin synchroniser; the external clocks must run well below clk_sys
  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] meta_nxt;
  logic [SYNC_W-1:0] pin_s_r;
  logic [SYNC_W-1:0] pin_s_nxt;
  logic [1:0] clk_d_r;
  logic [1:0] clk_d_nxt;

  assign pins = {write_data_in, read_enable_two, read_enable_one, write_enable_two_load,
                 write_enable_one, read_clock, write_clock};

  always_comb begin
    meta_nxt = pins;
    pin_s_nxt = meta_r;
    clk_d_nxt = {pin_s_r[PIN_RCLK], pin_s_r[PIN_WCLK]};
  end

  always_ff @(posedge clk_sys) begin
    meta_r <= meta_nxt;
    pin_s_r <= pin_s_nxt;
    clk_d_r <= clk_d_nxt;
  end

  logic wclk_rise;
  logic rclk_rise;
  logic we_one_n;
  logic we_two_load;
  logic rd_en_n;
  logic [DATA_W-1:0] wdata_s;

  assign wclk_rise = pin_s_r[PIN_WCLK] & ~clk_d_r[0];
  assign rclk_rise = pin_s_r[PIN_RCLK] & ~clk_d_r[1];
  assign we_one_n = pin_s_r[PIN_WE_ONE];
  assign we_two_load = pin_s_r[PIN_WE_TWO];
  assign rd_en_n = pin_s_r[PIN_RE_ONE] | pin_s_r[PIN_RE_TWO];
  assign wdata_s = pin_s_r[PIN_DATA +: DATA_W];

  // Configuration: caught continuously while reset is held, frozen after
  logic two_en_r;
  logic two_en_nxt;

  always_comb begin
    two_en_nxt = two_en_r;
    if (!resetn) begin
      two_en_nxt = we_two_load;
    end
  end

  always_ff @(posedge clk_sys) begin
    two_en_r <= two_en_nxt;
  end

  // Access decode
  logic full_flag_n_r;
  logic empty_flag_r;
  logic fifo_wr;
  logic fifo_rd;
  logic off_wr;
  logic off_rd;

  // Same enable pair in both modes: enable one low, pin high
  assign fifo_wr = wclk_rise & ~we_one_n & we_two_load & full_flag_n_r;
  assign fifo_rd = rclk_rise & ~rd_en_n & empty_flag_r & (two_en_r | we_two_load);
  assign off_wr = wclk_rise & ~two_en_r & ~we_one_n & ~we_two_load;
  assign off_rd = rclk_rise & ~two_en_r & ~rd_en_n & ~we_two_load;

  // Pointers
  logic [PW-1:0] wptr_r;
  logic [PW-1:0] wptr_nxt;
  logic [PW-1:0] rptr_r;
  logic [PW-1:0] rptr_nxt;
  logic [PW-1:0] count_nxt;

  always_comb begin
    wptr_nxt = wptr_r;
    rptr_nxt = rptr_r;
    if (fifo_wr) begin
      wptr_nxt = wptr_r + PTR_ONE;
    end
    if (fifo_rd) begin
      rptr_nxt = rptr_r + PTR_ONE;
    end
    count_nxt = wptr_nxt - rptr_nxt;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wptr_r <= PTR_ZERO;
      rptr_r <= PTR_ZERO;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
    end
  end

  // Offset registers and their two sequence positions
  logic [OFF_W-1:0] off_r [OFF_NUM];
  logic [OFF_W-1:0] off_nxt [OFF_NUM];
  logic [1:0] wsel_r;
  logic [1:0] wsel_nxt;
  logic [1:0] rsel_r;
  logic [1:0] rsel_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < OFF_NUM; gi++) begin : g_off
      localparam logic [OFF_W-1:0] DEF = ((gi % 2) == 0) ? OFF_LO_DEFAULT : OFF_HI_DEFAULT;
      always_comb begin
        off_nxt[gi] = off_r[gi];
        if (off_wr && wsel_r == 2'(gi)) begin
          off_nxt[gi] = wdata_s[OFF_W-1:0];
        end
      end
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          off_r[gi] <= DEF;
        end else begin
          off_r[gi] <= off_nxt[gi];
        end
      end
    end
  endgenerate

  // Positions wrap naturally at four and are untouched when the pin is high
  always_comb begin
    wsel_nxt = off_wr ? wsel_r + 2'h1 : wsel_r;
    rsel_nxt = off_rd ? rsel_r + 2'h1 : rsel_r;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wsel_r <= OFF_EMPTY_LO;
      rsel_r <= OFF_EMPTY_LO;
    end else begin
      wsel_r <= wsel_nxt;
      rsel_r <= rsel_nxt;
    end
  end

  logic [OFF_CAT_W-1:0] empty_cat;
  logic [OFF_CAT_W-1:0] full_cat;
  logic [PW-1:0] n_val;
  logic [PW-1:0] m_val;

  assign empty_cat = {off_r[OFF_EMPTY_HI], off_r[OFF_EMPTY_LO]};
  assign full_cat = {off_r[OFF_FULL_HI], off_r[OFF_FULL_LO]};
  // Bits above the pointer width are ignored
  assign n_val = {1'b0, empty_cat[AW-1:0]};
  assign m_val = {1'b0, full_cat[AW-1:0]};

  // Storage
  logic [DATA_W-1:0] mem_q;

  sfo_mem #(
    .DW(DATA_W),
    .AW(AW)
  ) u_mem (
    .clk_sys(clk_sys),
    .wr_en(fifo_wr),
    .wr_addr(wptr_r[AW-1:0]),
    .wr_data(wdata_s),
    .rd_en(fifo_rd),
    .rd_addr(rptr_r[AW-1:0]),
    .rd_data(mem_q)
  );

  // Output register: FIFO words land one cycle after the array read
  logic [DATA_W-1:0] dout_r;
  logic [DATA_W-1:0] dout_nxt;
  logic rd_pend_r;
  logic rd_pend_nxt;

  always_comb begin
    dout_nxt = dout_r;
    rd_pend_nxt = fifo_rd;
    if (rd_pend_r) begin
      dout_nxt = mem_q;
    end else if (off_rd) begin
      dout_nxt = {1'b0, off_r[rsel_r]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dout_r <= '0;
      rd_pend_r <= 1'b0;
    end else begin
      dout_r <= dout_nxt;
      rd_pend_r <= rd_pend_nxt;
    end
  end

  // Flags, each re-evaluated only on its own port's clock
  logic almost_full_flag_r;
  logic almost_empty_flag_r;
  logic full_flag_n_nxt;
  logic empty_flag_nxt;
  logic almost_full_flag_nxt;
  logic almost_empty_flag_nxt;

  always_comb begin
    full_flag_n_nxt = full_flag_n_r;
    almost_full_flag_nxt = almost_full_flag_r;
    empty_flag_nxt = empty_flag_r;
    almost_empty_flag_nxt = almost_empty_flag_r;
    if (wclk_rise) begin
      full_flag_n_nxt = (count_nxt != DEPTH_P);
      almost_full_flag_nxt = (count_nxt < DEPTH_P - m_val);
    end
    if (rclk_rise) begin
      empty_flag_nxt = (count_nxt != PTR_ZERO);
      almost_empty_flag_nxt = (count_nxt > n_val);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      full_flag_n_r <= 1'b1;
      almost_full_flag_r <= 1'b1;
      empty_flag_r <= 1'b0;
      almost_empty_flag_r <= 1'b0;
    end else begin
      full_flag_n_r <= full_flag_n_nxt;
      almost_full_flag_r <= almost_full_flag_nxt;
      empty_flag_r <= empty_flag_nxt;
      almost_empty_flag_r <= almost_empty_flag_nxt;
    end
  end

  assign read_data_out = dout_r;
  assign full_flag_n = full_flag_n_r;
  assign empty_flag = empty_flag_r;
  assign almost_full_flag = almost_full_flag_r;
  assign almost_empty_flag = almost_empty_flag_r;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  mode_capture_a: assert property ($rose(resetn) |-> two_en_r == $past(we_two_load))
    else $error("mode not taken from pin level during reset");
  two_en_lock_a: assert property (two_en_r |=> $stable(empty_cat) && $stable(full_cat))
    else $error("offset access in two-enable mode");
  full_block_a: assert property (!full_flag_n_r |-> !fifo_wr ##1 $stable(wptr_r))
    else $error("write taken while full");
  empty_block_a: assert property (!empty_flag_r && rclk_rise |=> $stable(rptr_r))
    else $error("read taken while empty");
  full_set_a: assert property (wclk_rise && count_nxt == DEPTH_P |=> !full_flag_n_r)
    else $error("full flag not low at depth");
  wr_flags_hold_a: assert property (!wclk_rise |=> $stable(full_flag_n_r) && $stable(almost_full_flag_r))
    else $error("write flags moved without write clock");
  rd_flags_hold_a: assert property (!rclk_rise |=> $stable(empty_flag_r) && $stable(almost_empty_flag_r))
    else $error("read flags moved without read clock");
  offset_store_a: assert property (off_wr |=> off_r[$past(wsel_r)] == $past(wdata_s[OFF_W-1:0]))
    else $error("offset register not loaded in sequence");
  almost_empty_a: assert property (rclk_rise && count_nxt <= n_val |=> !almost_empty_flag_r)
    else $error("almost-empty flag not low at offset");
  almost_full_a: assert property (wclk_rise && count_nxt >= DEPTH_P - m_val |=> !almost_full_flag_r)
    else $error("almost-full flag not low at threshold");
  reset_flags_a: assert property (disable iff (1'b0) !resetn |=> full_flag_n_r && !empty_flag_r && dout_r == '0)
    else $error("flags wrong after reset");
endmodule : sfo_top

// *** common/sfo_pkg.sv ***
package sfo_pkg;
  localparam int DATA_W = 9;
  localparam int FIFO_DEPTH = 256;
  localparam int OFF_W = 8;
  localparam int OFF_NUM = 4;
  localparam int OFF_CAT_W = 2 * OFF_W;
  localparam int SYNC_W = 6 + DATA_W;

  // Position of each offset register in the load and read-back sequence
  localparam logic [1:0] OFF_EMPTY_LO = 2'h0;
  localparam logic [1:0] OFF_EMPTY_HI = 2'h1;
  localparam logic [1:0] OFF_FULL_LO = 2'h2;
  localparam logic [1:0] OFF_FULL_HI = 2'h3;

  localparam logic [OFF_W-1:0] OFF_LO_DEFAULT = 8'h07;
  localparam logic [OFF_W-1:0] OFF_HI_DEFAULT = 8'h00;

  // Bit positions of the pin bundle passed through the synchroniser
  localparam int PIN_WCLK = 0;
  localparam int PIN_RCLK = 1;
  localparam int PIN_WE_ONE = 2;
  localparam int PIN_WE_TWO = 3;
  localparam int PIN_RE_ONE = 4;
  localparam int PIN_RE_TWO = 5;
  localparam int PIN_DATA = 6;
endpackage : sfo_pkg

// *** logic/sfo_mem.sv ***
`timescale 1ns/10ps
module sfo_mem #(
  parameter int DW = 9,
  parameter int AW = 8
) (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem_r [2**AW];

  // No reset on the array: contents are undefined until written
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem_r[rd_addr];
    end
  end
endmodule : sfo_mem

// *** tb/sfo_far_end.sv ***
`timescale 1ns/10ps
module sfo_far_end
  import sfo_pkg::*;
(
  input wire logic clk_sys,
  output logic write_clock,
  output logic read_clock,
  output logic write_enable_one,
  output logic write_enable_two_load,
  output logic read_enable_one,
  output logic read_enable_two,
  output logic [sfo_pkg::DATA_W-1:0] write_data_in,
  input wire logic [sfo_pkg::DATA_W-1:0] read_data_out
);
  initial begin
    write_clock = 1'b0;
    read_clock = 1'b0;
    write_enable_one = 1'b1;
    write_enable_two_load = 1'b0;
    read_enable_one = 1'b1;
    read_enable_two = 1'b1;
    write_data_in = 9'h000;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : hold

  task automatic set_mode_pin(input logic pin_lvl);
    write_enable_two_load <= pin_lvl;
    hold(16);
  endtask : set_mode_pin

  // Pins are oversampled, so every level stands four block cycles around each rise
  task automatic wr(input logic en1, input logic pin_lvl, input logic [DATA_W-1:0] d);
    write_enable_one <= en1;
    write_enable_two_load <= pin_lvl;
    write_data_in <= d;
    hold(4);
    write_clock <= 1'b1;
    hold(4);
    write_clock <= 1'b0;
    hold(4);
    write_enable_one <= 1'b1;
    write_data_in <= ~d;
    hold(1);
  endtask : wr

  // Reads and writes never overlap: each access completes before the next starts
  task automatic rd(input logic ren, output logic [DATA_W-1:0] q);
    read_enable_one <= ren;
    read_enable_two <= ren;
    hold(4);
    read_clock <= 1'b1;
    hold(4);
    read_clock <= 1'b0;
    hold(4);
    q = read_data_out;
    read_enable_one <= 1'b1;
    read_enable_two <= 1'b1;
    hold(1);
  endtask : rd
endmodule : sfo_far_end

// *** tb/sfo_top_bench.sv ***
`timescale 1ns/10ps
module sfo_top_bench;
  import sfo_pkg::*;
  localparam int DEPTH = 256;
  logic clk_sys;
  logic resetn;
  logic write_clock, read_clock, write_enable_one, write_enable_two_load;
  logic read_enable_one, read_enable_two;
  logic [DATA_W-1:0] write_data_in, read_data_out, q;
  logic full_flag_n, empty_flag, almost_full_flag, almost_empty_flag;
  logic [DATA_W-1:0] exp_off [4] = '{9'h002, 9'h000, 9'h003, 9'h001};
  int n_errors = 0;
  int num_checks = 0;

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  sfo_top #(.DEPTH(DEPTH)) i_dut (.clk_sys(clk_sys), .resetn(resetn), .write_clock(write_clock),
    .read_clock(read_clock), .write_enable_one(write_enable_one),
    .write_enable_two_load(write_enable_two_load), .read_enable_one(read_enable_one),
    .read_enable_two(read_enable_two), .write_data_in(write_data_in), .read_data_out(read_data_out),
    .full_flag_n(full_flag_n), .empty_flag(empty_flag), .almost_full_flag(almost_full_flag),
    .almost_empty_flag(almost_empty_flag));

  sfo_far_end i_far (.clk_sys(clk_sys), .write_clock(write_clock), .read_clock(read_clock),
    .write_enable_one(write_enable_one), .write_enable_two_load(write_enable_two_load),
    .read_enable_one(read_enable_one), .read_enable_two(read_enable_two),
    .write_data_in(write_data_in), .read_data_out(read_data_out));

  function automatic logic [DATA_W-1:0] word(input int k);
    return DATA_W'(k * 37);
  endfunction : word

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  task automatic do_reset(input logic pin_lvl);
    resetn <= 1'b0;
    i_far.set_mode_pin(pin_lvl);
    chk(read_data_out, 9'h000);
    chk({full_flag_n, almost_full_flag, empty_flag, almost_empty_flag}, 9'h00c);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask : do_reset

  // Fill to full and drain to empty, watching the full flags at each fill count and the empty flags at each drain count
  task automatic fill_drain(input int n, input int m);
    int c;
    for (int k = 1; k <= DEPTH; k++) begin
      i_far.wr(1'b0, 1'b1, word(k));
      chk(full_flag_n, k != DEPTH);
      chk(almost_full_flag, k < DEPTH - m);
      if (k == 1) chk(empty_flag, 1'b0);
    end
    i_far.wr(1'b0, 1'b1, 9'h1ff);
    i_far.rd(1'b1, q);
    chk({empty_flag, almost_empty_flag}, 9'h003);
    for (int k = 1; k <= DEPTH; k++) begin
      i_far.rd(1'b0, q);
      c = DEPTH - k;
      chk(q, word(k));
      chk(empty_flag, c != 0);
      chk(almost_empty_flag, c > n);
      if (k == 1) begin
        chk(full_flag_n, 1'b0);
        i_far.wr(1'b1, 1'b1, 9'h000);
        chk(full_flag_n, 1'b1);
      end
    end
    i_far.rd(1'b0, q);
    chk(q, word(DEPTH));
  endtask : fill_drain

  initial begin
    repeat (100000) @(posedge clk_sys);
    n_errors++;
    end_of_test();
  end

  initial begin
    resetn = 1'b0;
    @(posedge clk_sys);
    do_reset(1'b0);
    for (int i = 0; i < 4; i++) begin
      i_far.rd(1'b0, q);
      chk(q, i[0] ? 9'h000 : 9'h007);
    end
    i_far.wr(1'b0, 1'b0, 9'h002);
    i_far.wr(1'b1, 1'b1, 9'h000);
    i_far.wr(1'b0, 1'b0, 9'h000);
    i_far.wr(1'b0, 1'b0, 9'h003);
    i_far.wr(1'b0, 1'b0, 9'h101);
    for (int i = 0; i < 4; i++) begin
      i_far.rd(1'b0, q);
      chk(q, exp_off[i]);
    end
    fill_drain(2, 3);
    do_reset(1'b1);
    i_far.wr(1'b0, 1'b0, 9'h0aa);
    i_far.wr(1'b1, 1'b1, 9'h0aa);
    fill_drain(7, 7);
    end_of_test();
  end
endmodule : sfo_top_bench
